// file: hw/rsr_clock_loss.sv
// clock_loss_detector: watches the system clock level for stalls
// assumes sys_clk_level is sampled synchronously to ref_clk
module rsr_clock_loss
  import rsr_pkg::*;
#(
  parameter int LOSS_CYCLES = RSR_LOSS_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic sys_clk_level,
  output logic timeout
);

  logic last_level_reg;
  logic [RSR_CNT_W-1:0] stall_cnt_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_level_reg <= 1'b0;
    end else begin
      last_level_reg <= sys_clk_level;
    end
  end

  // any edge restarts the one-shot; a level held too long fires it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stall_cnt_reg <= '0;
      timeout <= 1'b0;
    end else if (!enable || sys_clk_level != last_level_reg) begin
      stall_cnt_reg <= '0;
      timeout <= 1'b0;
    end else if (stall_cnt_reg == RSR_CNT_W'(LOSS_CYCLES)) begin
      stall_cnt_reg <= '0;
      timeout <= 1'b1;
    end else begin
      stall_cnt_reg <= stall_cnt_reg + 1'b1;
      timeout <= 1'b0;
    end
  end

endmodule

// file: hw/rsr_reset_source.sv
// reset_source_control register and system reset sequencer
// assumes rst is the power-on reset; all other inputs synchronous
// Functional notes
// - writing bit 5 high lets a low comparator output reset the device
// - bit 5 reads one when the comparator caused the last reset
// - writing one to bit 4 starts a full system reset at once
// - bit 4 reads one only after a software-forced reset
// - bit 3 is read-only, one after a watchdog overflow reset
// - bit 2 write enables or disables the clock loss detector
// - enabled clock loss detector resets the device when clock stops
// - writing bit 1 high makes a low supply indication reset the device
// - power-on flag reads one after power-on; other flags then untrusted
// - bit 6 is read-only, one after an illegal code memory access
// - clock level held longer than 100 us triggers a reset
// - bit 2 reads one only after a clock loss reset
// - comparator reset starts on a low comparator output; the hold ends on its count, not when the output rises
// - bit 0 is set on leaving a reset from the external pin
module rsr_reset_source
  import rsr_pkg::*;
#(
  parameter int HOLD_CYCLES = RSR_HOLD_CYC,
  parameter int LOSS_CYCLES = RSR_LOSS_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_rst_n,
  input wire logic cmp_out,
  input wire logic vdd_above,
  input wire logic wdt_overflow,
  input wire logic mem_error,
  input wire logic sys_clk_level,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sys_rst
);

  rsr_state_t state_reg;
  rsr_trig_t trig;
  logic [RSR_CNT_W-1:0] hold_cnt_reg;
  logic [7:0] cause_reg;
  logic [7:0] flags_reg;
  logic cmp_en_reg;
  logic mcd_en_reg;
  logic vdd_en_reg;
  logic loss_timeout;
  logic wr_hit;
  logic any_trig;
  logic rd_hit;
  logic enter_hold;
  logic exit_now;

  localparam logic [RSR_CNT_W-1:0] HOLD_LOAD = RSR_CNT_W'(HOLD_CYCLES);

  // the one address decode shared by the read and the write path
  function automatic logic reg_hit(input logic [7:0] addr);
    return addr == RSR_ADDR;
  endfunction

  // first matching source wins; the pin outranks internal sources
  function automatic logic [7:0] cause_of(input rsr_trig_t t);
    logic [7:0] c;
    c = 8'h00;
    if (t.pin) begin
      c[RSR_BIT_PIN] = 1'b1;
    end else if (t.vdd) begin
      c[RSR_BIT_POR] = 1'b1;
    end else if (t.mem) begin
      c[RSR_BIT_MEM] = 1'b1;
    end else if (t.clock_loss_detector) begin
      c[RSR_BIT_MCD] = 1'b1;
    end else if (t.wdt) begin
      c[RSR_BIT_WDT] = 1'b1;
    end else if (t.cmp) begin
      c[RSR_BIT_CMP] = 1'b1;
    end else if (t.sw) begin
      c[RSR_BIT_SW] = 1'b1;
    end
    return c;
  endfunction

  rsr_clock_loss #(
    .LOSS_CYCLES(LOSS_CYCLES)
  ) u_loss (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(mcd_en_reg),
    .sys_clk_level(sys_clk_level),
    .timeout(loss_timeout)
  );

  // software cannot run while the device is held in reset
  assign wr_hit = sfr_wr && reg_hit(sfr_addr) && state_reg == RSR_ST_RUN;
  // reads in hold are not taken either and return zero
  assign rd_hit = sfr_rd && reg_hit(sfr_addr) && state_reg == RSR_ST_RUN;

  always_comb begin
    trig.pin = !ext_rst_n;
    trig.vdd = vdd_en_reg && !vdd_above;
    trig.mem = mem_error;
    trig.clock_loss_detector = loss_timeout;
    trig.wdt = wdt_overflow;
    trig.cmp = cmp_en_reg && !cmp_out;
    trig.sw = wr_hit && sfr_wdata[RSR_BIT_SW];
    any_trig = |trig;
  end

  // any request in run enters hold; the exit waits for a released pin
  // and an empty count
  assign enter_hold = state_reg == RSR_ST_RUN && any_trig;
  assign exit_now = state_reg == RSR_ST_HOLD && !trig.pin &&
                    hold_cnt_reg == '0;

  // sequencer: power-on starts in hold, so the first release is timed too
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= RSR_ST_HOLD;
    end else begin
      case (state_reg)
        RSR_ST_RUN: begin
          if (any_trig) begin
            state_reg <= RSR_ST_HOLD;
          end
        end
        RSR_ST_HOLD: begin
          if (exit_now) begin
            state_reg <= RSR_ST_RUN;
          end
        end
        default: begin
          // an illegal code falls back to a fresh hold rather than run
          state_reg <= RSR_ST_HOLD;
        end
      endcase
    end
  end

  // the count sits loaded outside hold; a pin held low stretches the
  // reset until it is released
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_cnt_reg <= HOLD_LOAD;
    end else if (state_reg != RSR_ST_HOLD || trig.pin) begin
      hold_cnt_reg <= HOLD_LOAD;
    end else if (hold_cnt_reg != '0) begin
      hold_cnt_reg <= hold_cnt_reg - 1'b1;
    end
  end

  // cause latched at entry so a source that clears during hold still counts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_reg <= RSR_FLAGS_RESET;
    end else if (enter_hold) begin
      cause_reg <= cause_of(trig);
    end
  end

  // system reset rises with the entry edge and falls with the exit edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_rst <= 1'b1;
    end else if (exit_now) begin
      sys_rst <= 1'b0;
    end else if (state_reg != RSR_ST_RUN || any_trig) begin
      sys_rst <= 1'b1;
    end
  end

  // flags change only on the exit from reset, or to the power-on value while rst is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= RSR_FLAGS_RESET;
    end else if (exit_now) begin
      flags_reg <= cause_reg;
    end
  end

  // comparator and clock loss sources drop on every reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmp_en_reg <= 1'b0;
      mcd_en_reg <= 1'b0;
    end else if (state_reg == RSR_ST_HOLD) begin
      cmp_en_reg <= 1'b0;
      mcd_en_reg <= 1'b0;
    end else if (wr_hit && !trig.sw) begin
      cmp_en_reg <= sfr_wdata[RSR_BIT_CMP];
      mcd_en_reg <= sfr_wdata[RSR_BIT_MCD];
    end
  end

  // the supply source survives non-power-on resets, only power-on sets
  // it back; an early enable may reset the device if the monitor is
  // still unsettled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vdd_en_reg <= RSR_VDD_EN_RESET;
    end else if (wr_hit && !trig.sw && sfr_wdata[RSR_BIT_POR]) begin
      vdd_en_reg <= 1'b1;
    end
  end

  // bits 0, 3, 6, 7 ignore writes; reads have no side effect
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (rd_hit) begin
      sfr_rdata <= flags_reg & RSR_READ_MASK;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

endmodule

// file: include/rsr_pkg.sv
// reset source register package: address, bit layout, timing figures
// assumes a 25 MHz reference clock and one 8-bit special-function bus
package rsr_pkg;

  localparam logic [7:0] RSR_ADDR = 8'hef;

  // bit positions of reset_source_control
  localparam int RSR_BIT_PIN = 0;
  localparam int RSR_BIT_POR = 1;
  localparam int RSR_BIT_MCD = 2;
  localparam int RSR_BIT_WDT = 3;
  localparam int RSR_BIT_SW = 4;
  localparam int RSR_BIT_CMP = 5;
  localparam int RSR_BIT_MEM = 6;
  localparam int RSR_BIT_UNUSED = 7;

  localparam logic [7:0] RSR_FLAGS_RESET = 8'h02;
  localparam logic [7:0] RSR_READ_MASK = 8'h7f;
  localparam logic RSR_VDD_EN_RESET = 1'b1;

  // timing
  localparam int RSR_CLK_KHZ = 25000;
  localparam int RSR_LOSS_US = 100;
  localparam int RSR_LOSS_CYC = (RSR_LOSS_US * RSR_CLK_KHZ + 999) / 1000;
  localparam int RSR_HOLD_CYC = 16;
  localparam int RSR_CNT_W = 12;

  typedef enum logic [1:0] {
    RSR_ST_RUN = 2'b01,
    RSR_ST_HOLD = 2'b10
  } rsr_state_t;

  // one bit for every source that can start a system reset
  typedef struct packed {
    logic pin;
    logic vdd;
    logic mem;
    logic clock_loss_detector;
    logic wdt;
    logic cmp;
    logic sw;
  } rsr_trig_t;

endpackage

// file: verif/rsr_asserts.sv
// port assertions for the reset source register
// bound onto rsr_reset_source at the foot of this file
module rsr_asserts
  import rsr_pkg::*;
#(parameter int HOLD_CYCLES = RSR_HOLD_CYC) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_rst_n,
  input wire logic vdd_above,
  input wire logic wdt_overflow,
  input wire logic mem_error,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sys_rst
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic hit;
  int hi_cnt;
  assign hit = sfr_addr == RSR_ADDR && !sys_rst;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) hi_cnt <= 0;
    else hi_cnt <= sys_rst ? hi_cnt + 1 : 0;
  a_bit7_zero: assert property (!sfr_rdata[7])
    else $error("bit 7 read as one");
  a_read_idle: assert property (!(sfr_rd && hit) |=> sfr_rdata == 8'h00)
    else $error("read data without a read");
  a_sw_reset: assert property (sfr_wr && hit && sfr_wdata[4] |=> sys_rst)
    else $error("software reset missed");
  a_pin_reset: assert property (!ext_rst_n |=> sys_rst)
    else $error("pin reset missed");
  a_pin_exit: assert property ($rose(ext_rst_n) |-> sys_rst[*2])
    else $error("pin reset left early");
  a_wdt_reset: assert property (wdt_overflow && !sys_rst |=> sys_rst)
    else $error("watchdog reset missed");
  a_mem_reset: assert property (mem_error && !sys_rst |=> sys_rst)
    else $error("memory error reset missed");
  a_vdd_reset: assert property (!vdd_above && !sys_rst |=> sys_rst)
    else $error("supply reset missed");
  a_hold_len: assert property ($fell(sys_rst) |-> hi_cnt >= HOLD_CYCLES)
    else $error("reset hold too short");
  c_sw: cover property (sfr_wr && hit && sfr_wdata[4]);
  c_read: cover property (sfr_rdata != 8'h00);
  c_exit: cover property ($fell(sys_rst));
endmodule
bind rsr_reset_source rsr_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .ext_rst_n(ext_rst_n),
  .vdd_above(vdd_above), .wdt_overflow(wdt_overflow), .mem_error(mem_error),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sys_rst(sys_rst));

// file: verif/tb.sv
// self-checking bench for rsr_reset_source
// assumes rsr_pkg and the checker are compiled first
module tb
  import rsr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] en; int src; logic [7:0] exp;} rsr_row_t;
  rsr_row_t rows [7] = '{'{8'h10, 0, 8'h10}, '{8'h20, 1, 8'h20},
    '{8'h04, 6, 8'h04}, '{8'h00, 2, 8'h08}, '{8'h00, 3, 8'h40},
    '{8'h00, 5, 8'h02}, '{8'h00, 4, 8'h01}};
  logic ref_clk, rst, ext_rst_n, cmp_out, vdd_above, wdt_overflow;
  logic mem_error, sys_clk_level, sfr_wr, sfr_rd, sys_rst, clk_run;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  rsr_reset_source #(.HOLD_CYCLES(2), .LOSS_CYCLES(20)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .ext_rst_n(ext_rst_n), .cmp_out(cmp_out),
    .vdd_above(vdd_above), .wdt_overflow(wdt_overflow),
    .mem_error(mem_error), .sys_clk_level(sys_clk_level),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sys_rst(sys_rst));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1 check(sfr_rdata, exp);
  endtask
  // bounded wait, sampled 1 ns after the edge so outputs have settled
  task automatic wait_rst(input logic lvl);
    int n;
    n = 0;
    #1;
    while (sys_rst !== lvl && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check({7'h00, sys_rst}, {7'h00, lvl});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // stopping clk_run freezes the watched clock level
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (clk_run) sys_clk_level <= ~sys_clk_level;
    if (cyc == 2000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {rst, ext_rst_n, cmp_out, vdd_above, clk_run} = 5'h1f;
    {wdt_overflow, mem_error, sys_clk_level, sfr_wr, sfr_rd} = 5'h00;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    wait_rst(1'b0);
    rd_chk(RSR_ADDR, RSR_FLAGS_RESET);
    foreach (rows[i]) begin
      sfr_write(RSR_ADDR, rows[i].en);
      case (rows[i].src)
        1: cmp_out <= 1'b0;
        2: wdt_overflow <= 1'b1;
        3: mem_error <= 1'b1;
        4: ext_rst_n <= 1'b0;
        5: vdd_above <= 1'b0;
        6: clk_run <= 1'b0;
        default: ;
      endcase
      wait_rst(1'b1);
      @(posedge ref_clk);
      {ext_rst_n, cmp_out, vdd_above, clk_run} <= 4'hf;
      {wdt_overflow, mem_error} <= 2'b00;
      wait_rst(1'b0);
      rd_chk(RSR_ADDR, rows[i].exp);
      rd_chk(RSR_ADDR, rows[i].exp);
    end
    // supply monitor is settled here, so selecting it is harmless
    sfr_write(RSR_ADDR, 8'h02);
    // enable then disable clock loss, try read-only bits, unmapped write
    sfr_write(RSR_ADDR, 8'h04);
    sfr_write(RSR_ADDR, 8'hc8);
    cmp_out <= 1'b0;
    clk_run <= 1'b0;
    sfr_write(8'hee, 8'h10);
    repeat (40) @(posedge ref_clk);
    {cmp_out, clk_run} <= 2'b11;
    rd_chk(RSR_ADDR, 8'h01);
    rd_chk(8'hee, 8'h00);
    // pin and watchdog together: the pin outranks, one flag only
    @(posedge ref_clk);
    ext_rst_n <= 1'b0;
    wdt_overflow <= 1'b1;
    wait_rst(1'b1);
    @(posedge ref_clk);
    {ext_rst_n, wdt_overflow} <= 2'b10;
    wait_rst(1'b0);
    rd_chk(RSR_ADDR, 8'h01);
    // a second power-on mid-run brings back the power-on flag alone
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({7'h00, sys_rst}, 8'h01);
    rst <= 1'b0;
    wait_rst(1'b0);
    rd_chk(RSR_ADDR, RSR_FLAGS_RESET);
    give_verdict();
  end
endmodule
